/* File: bench/lpc_ctrl_props.sv */
// Purpose: Port timing checks for the LPDDR command controller
// Assumes: Slow grade, one CLK domain, CK made inside the block
// Notes: Activate distances are taken between REQ_ACK cycles; refresh and CKE distances start at the pins
`timescale 1ns/1ns
`default_nettype none
module lpc_ctrl_props #(
	parameter int T_TQ_CYC = 50
) (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic REQ_VALID,
	input wire logic REQ_READY,
	input wire logic REQ_ACK,
	input wire logic RD_VALID,
	input wire logic TS_ENABLE,
	input wire logic TS_READY,
	input wire logic FREQ_CHANGE_OK,
	input wire lpc_pkg::lpc_cmd_t CMD,
	input wire logic DQS_O,
	input wire logic DQS_OE
);
	// ------------------------------
	// Helper counters
	// ------------------------------
	logic [31:0] rc_q [4];
	logic [31:0] rrd_q, ref_q, rfc_q, cke_q, ts_q;
	wire logic live = CMD.cke && !CMD.cs_n;
	wire logic is_ref = live && CMD.rcw_n == lpc_pkg::PIN_REF;
	wire logic new_act = REQ_ACK && live && CMD.rcw_n == lpc_pkg::PIN_ACT;
	wire logic new_wr = REQ_ACK && live && CMD.rcw_n == lpc_pkg::PIN_WRITE;
	// EXIT shows NOP pins; only real commands are spaced
	wire logic new_cmd = REQ_ACK && live && CMD.rcw_n != lpc_pkg::PIN_NOP;
	// Any cycle with CKE low restarts the refresh distance, in power-down as well as in self refresh
	always_ff @(posedge CLK) begin
		for (int b = 0; b < 4; b++) begin
			rc_q[b] <= !RESET_N ? 32'hFF : (new_act && CMD.ba == 2'(b)) ? 32'h0 : rc_q[b] + 32'h1;
		end
		rrd_q <= !RESET_N ? 32'hFF : new_act ? 32'h0 : rrd_q + 32'h1;
		ref_q <= (!RESET_N || is_ref || !CMD.cke) ? 32'h0 : ref_q + 32'h1;
		rfc_q <= !RESET_N ? 32'hFF : is_ref ? 32'h0 : rfc_q + 32'h1;
		cke_q <= (!RESET_N || !CMD.cke) ? 32'h0 : cke_q + 32'h1;
		ts_q <= (!RESET_N || !TS_ENABLE) ? 32'h0 : ts_q + 32'h1;
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	property p_ack; REQ_ACK |-> $past(REQ_VALID && REQ_READY) ##1 !REQ_ACK; endproperty
	a_ack: assert property (p_ack) else $error("ack without take");
	property p_rc; new_act |-> rc_q[CMD.ba] + 32'h1 >= 32'(lpc_pkg::T_RC_SLOW_CYC); endproperty
	a_rc: assert property (p_rc) else $error("same bank activate too close");
	property p_rrd; new_act |-> rrd_q + 32'h1 >= 32'(lpc_pkg::T_RRD_SLOW_CYC); endproperty
	a_rrd: assert property (p_rrd) else $error("activates too close");
	property p_rfc; new_cmd |-> rfc_q + 32'h1 >= 32'(lpc_pkg::T_RFC_CYC); endproperty
	a_rfc: assert property (p_rfc) else $error("command inside refresh");
	property p_refi; ref_q <= 8 * 32'(lpc_pkg::T_REFI_CYC) + 32'h40; endproperty
	a_refi: assert property (p_refi) else $error("refresh postponed too long");
	property p_wr;
		new_wr |-> DQS_OE && !DQS_O ##1 DQS_OE && !DQS_O ##1 DQS_OE && !DQS_O ##1 DQS_O;
	endproperty
	a_wr: assert property (p_wr) else $error("write strobe misplaced");
	property p_freq; CMD.cke && $past(CMD.cke) |-> !FREQ_CHANGE_OK; endproperty
	a_freq: assert property (p_freq) else $error("freq window while clocked");
	property p_xp; new_cmd |-> cke_q >= 32'(lpc_pkg::T_XP_CYC) + 32'h1; endproperty
	a_xp: assert property (p_xp) else $error("command too soon after exit");
	property p_ts; $rose(TS_READY) |-> ts_q >= 32'(T_TQ_CYC); endproperty
	a_ts: assert property (p_ts) else $error("sensor ready early");
	c_wr: cover property (new_wr);
	c_ref: cover property (is_ref);
	c_rd: cover property (RD_VALID);
endmodule : lpc_ctrl_props
bind lpc_ctrl lpc_ctrl_props #(.T_TQ_CYC(T_TQ_CYC)) i_lpc_ctrl_props (.CLK(CLK), .RESET_N(RESET_N),
	.REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ_ACK(REQ_ACK), .RD_VALID(RD_VALID),
	.TS_ENABLE(TS_ENABLE), .TS_READY(TS_READY), .FREQ_CHANGE_OK(FREQ_CHANGE_OK), .CMD(CMD),
	.DQS_O(DQS_O), .DQS_OE(DQS_OE));
`default_nettype wire

/* File: bench/lpc_ctrl_test.sv */
// Purpose: Directed bench for the LPDDR command controller
// Assumes: Slow grade, CL 3, sensor wait cut to 50 cycles
// Notes: Inputs change on falling CLK; distances counted at REQ_ACK
`timescale 1ns/1ns
`default_nettype none
module lpc_ctrl_test;
	localparam int TQ = 50;
	logic CLK = 1'b0;
	logic RESET_N = 1'b0;
	logic REQ_VALID = 1'b0;
	lpc_pkg::lpc_op_t REQ_CMD = lpc_pkg::OP_NOP;
	logic [1:0] REQ_BANK = 2'h0;
	logic [13:0] REQ_ADDR = 14'h0000;
	logic [31:0] REQ_WDATA = 32'h0000_0000;
	logic TS_ENABLE = 1'b0;
	logic REQ_READY, REQ_ACK, RD_VALID, TS_READY, FREQ_CHANGE_OK, CK, CK_N, DQ_OE, DQS_O, DQS_OE;
	logic [31:0] RD_DATA;
	logic [15:0] DQ_O, m_dq;
	logic m_dqs;
	logic ref_q = 1'b0;
	lpc_pkg::lpc_cmd_t CMD;
	int fails = 0;
	int n_compared = 0;
	int cyc = 0;
	int n_ref = 0;
	int t0, t1, t2;
	wire logic [15:0] dq_w = DQ_OE ? DQ_O : m_dq;
	wire logic dqs_w = DQS_OE ? DQS_O : m_dqs;
	wire logic is_ref = CMD.cke && !CMD.cs_n && CMD.rcw_n == lpc_pkg::PIN_REF;
	lpc_ctrl #(.FAST_GRADE(1'b0), .CAS_LAT(3), .T_TQ_CYC(TQ)) i_lpc_ctrl (.CLK(CLK),
		.RESET_N(RESET_N), .REQ_VALID(REQ_VALID), .REQ_CMD(REQ_CMD), .REQ_BANK(REQ_BANK),
		.REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .REQ_READY(REQ_READY), .REQ_ACK(REQ_ACK),
		.RD_VALID(RD_VALID), .RD_DATA(RD_DATA), .TS_ENABLE(TS_ENABLE), .TS_READY(TS_READY),
		.FREQ_CHANGE_OK(FREQ_CHANGE_OK), .CK(CK), .CK_N(CK_N), .CMD(CMD), .DQ_O(DQ_O),
		.DQ_OE(DQ_OE), .DQ_I(dq_w), .DQS_O(DQS_O), .DQS_OE(DQS_OE), .DQS_I(dqs_w));
	lpc_mem_model #(.CL(3)) i_lpc_mem_model (.CK(CK), .CMD(CMD), .DQ(m_dq), .DQS(m_dqs));
	always #5 CLK = ~CLK;
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		ref_q <= is_ref;
		if (is_ref && !ref_q) n_ref <= n_ref + 1;
		if (cyc == 9000) begin
			fails = fails + 1;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim
	task automatic chk(input bit ok, input string msg);
		n_compared++;
		if (!ok) begin
			fails++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : chk
	// Keep holds valid so a chained request goes in the first slot where it is legal
	task automatic req(input lpc_pkg::lpc_op_t op, input logic [1:0] b, input logic [13:0] a,
		input logic [31:0] wd, input bit keep, output int t);
		int n;
		REQ_VALID = 1'b1;
		REQ_CMD = op;
		REQ_BANK = b;
		REQ_ADDR = a;
		REQ_WDATA = wd;
		n = 0;
		@(negedge CLK);
		while (REQ_ACK !== 1'b1 && n < 100) begin
			@(negedge CLK);
			n++;
		end
		t = cyc;
		if (n >= 100) chk(1'b0, "no ack");
		if (!keep) begin
			REQ_VALID = 1'b0;
			@(negedge CLK);
		end
	endtask : req
	task automatic t_exit();
		repeat (2) @(negedge CLK);
		chk(FREQ_CHANGE_OK === 1'b1, "no freq window in power-down");
		chk(CK_N === ~CK, "clock pair not complementary");
		req(lpc_pkg::OP_EXIT, 2'h0, 14'h0000, 32'h0, 1'b1, t0);
		req(lpc_pkg::OP_ACT, 2'h0, 14'h0123, 32'h0, 1'b1, t1);
		chk(t1 - t0 >= lpc_pkg::T_XP_CYC, "act soon after exit");
		chk(CMD.rcw_n === lpc_pkg::PIN_ACT && FREQ_CHANGE_OK === 1'b0, "act pins");
	endtask : t_exit
	task automatic t_bank();
		req(lpc_pkg::OP_ACT, 2'h1, 14'h0456, 32'h0, 1'b0, t2);
		chk(t2 - t1 >= lpc_pkg::T_RRD_SLOW_CYC, "activates close");
		repeat (4) @(negedge CLK);
		req(lpc_pkg::OP_PRE, 2'h0, 14'h0000, 32'h0, 1'b1, t0);
		req(lpc_pkg::OP_ACT, 2'h0, 14'h0789, 32'h0, 1'b0, t2);
		chk(t2 - t1 >= lpc_pkg::T_RC_SLOW_CYC && t2 - t0 >= lpc_pkg::T_RP_SLOW_CYC, "reopen");
	endtask : t_bank
	task automatic t_write();
		req(lpc_pkg::OP_WRITE, 2'h1, 14'h0410, 32'hC3A5_5A3C, 1'b0, t0);
		@(negedge CLK);
		chk(DQ_OE === 1'b1 && DQ_O === 16'h5A3C, "first beat");
		@(negedge CLK);
		chk(DQS_O === 1'b1 && DQ_O === 16'hC3A5, "second beat");
		req(lpc_pkg::OP_ACT, 2'h1, 14'h0321, 32'h0, 1'b0, t1);
		chk(t1 - t0 >= lpc_pkg::T_DAL_SLOW_CYC + 5, "act in write recovery");
	endtask : t_write
	task automatic t_read();
		req(lpc_pkg::OP_READ, 2'h0, 14'h0020, 32'h0, 1'b0, t0);
		t1 = 0;
		while (RD_VALID !== 1'b1 && t1 < 40) begin
			@(negedge CLK);
			t1++;
		end
		chk(RD_VALID === 1'b1 && RD_DATA === 32'h96C3_5A3C, "read word");
	endtask : t_read
	task automatic t_ref();
		repeat (6) @(negedge CLK);
		req(lpc_pkg::OP_PRE, 2'h0, 14'h0400, 32'h0, 1'b1, t0);
		req(lpc_pkg::OP_REF, 2'h0, 14'h0000, 32'h0, 1'b1, t1);
		req(lpc_pkg::OP_ACT, 2'h2, 14'h0111, 32'h0, 1'b0, t2);
		chk(t2 - t1 >= lpc_pkg::T_RFC_CYC, "act inside refresh");
	endtask : t_ref
	task automatic t_sref();
		repeat (6) @(negedge CLK);
		req(lpc_pkg::OP_PRE, 2'h0, 14'h0400, 32'h0, 1'b1, t0);
		req(lpc_pkg::OP_SREF, 2'h0, 14'h0000, 32'h0, 1'b0, t0);
		repeat (10) @(negedge CLK);
		chk(FREQ_CHANGE_OK === 1'b1 && CMD.cke === 1'b0, "no freq window");
		req(lpc_pkg::OP_EXIT, 2'h0, 14'h0000, 32'h0, 1'b1, t1);
		req(lpc_pkg::OP_ACT, 2'h3, 14'h0222, 32'h0, 1'b0, t2);
		chk(t2 - t1 >= lpc_pkg::T_XSR_CYC, "act soon after self refresh");
	endtask : t_sref
	task automatic t_post();
		t0 = n_ref;
		repeat (8 * lpc_pkg::T_REFI_CYC + 100) @(negedge CLK);
		chk(n_ref > t0, "refresh never forced");
	endtask : t_post
	task automatic t_ts();
		TS_ENABLE = 1'b1;
		t0 = 0;
		while (TS_READY !== 1'b1 && t0 < TQ + 10) begin
			@(negedge CLK);
			t0++;
		end
		chk(t0 >= TQ && t0 <= TQ + 2, "sensor ready time");
		TS_ENABLE = 1'b0;
		repeat (2) @(negedge CLK);
		chk(TS_READY === 1'b0, "sensor ready held");
	endtask : t_ts
	task automatic t_pdn();
		repeat (6) @(negedge CLK);
		req(lpc_pkg::OP_PDN, 2'h0, 14'h0000, 32'h0, 1'b0, t0);
		repeat (2) @(negedge CLK);
		chk(FREQ_CHANGE_OK === 1'b1 && CMD.cke === 1'b0, "no power-down window");
		req(lpc_pkg::OP_EXIT, 2'h0, 14'h0000, 32'h0, 1'b1, t1);
		req(lpc_pkg::OP_ACT, 2'h1, 14'h0333, 32'h0, 1'b0, t2);
		chk(t2 - t1 >= lpc_pkg::T_XP_CYC, "act soon after power-down exit");
	endtask : t_pdn
	initial begin
		repeat (20) @(negedge CLK);
		RESET_N = 1'b1;
		t_exit();
		t_bank();
		t_write();
		t_read();
		t_ref();
		t_sref();
		t_post();
		t_ts();
		t_pdn();
		end_sim();
	end
endmodule : lpc_ctrl_test
`default_nettype wire

/* File: bench/lpc_mem_model.sv */
// Purpose: Behavioural memory answering reads on strobe and data
// Assumes: Burst length two, one read in flight
// Notes: Idle data shows the inverse of the last beat
`timescale 1ns/1ns
`default_nettype none
module lpc_mem_model #(
	parameter int CL = 3,
	parameter int T_AC_NS = 3,
	parameter logic [31:0] RD_WORD = 32'h96C3_5A3C
) (
	input wire logic CK,
	input wire lpc_pkg::lpc_cmd_t CMD,
	output logic [15:0] DQ,
	output logic DQS
);
	wire logic rd_reg = CMD.cke && !CMD.cs_n && CMD.rcw_n == lpc_pkg::PIN_READ;
	initial begin
		DQ = 16'h0000;
		DQS = 1'b0;
	end
	// Strobe idles low, as a weak pull-down would hold it
	always @(posedge CK) begin
		if (rd_reg === 1'b1) begin
			repeat (CL - 1) @(posedge CK);
			#T_AC_NS;
			DQS = 1'b1;
			DQ = RD_WORD[15:0];
			@(negedge CK);
			#T_AC_NS;
			DQS = 1'b0;
			DQ = RD_WORD[31:16];
			@(posedge CK);
			#T_AC_NS;
			DQ = ~RD_WORD[31:16];
		end
	end
endmodule : lpc_mem_model
`default_nettype wire

/* File: logic/lpc_ctrl.sv */
// Purpose: Host controller pacing commands, strobes and low-power exits of an LPDDR part
// Assumes: One command slot per CK period, burst length two, user keeps tRCD and tRAS
// Notes: CK is CLK divided by two and driven out; no second clock domain
`timescale 1ns/1ns
`default_nettype none
module lpc_ctrl #(
	parameter bit FAST_GRADE = 1'b0,
	parameter int CAS_LAT = 3,
	parameter int T_TQ_CYC = lpc_pkg::T_TQ_CYC_DFLT
) (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic REQ_VALID,
	input wire lpc_pkg::lpc_op_t REQ_CMD,
	input wire logic [1:0] REQ_BANK,
	input wire logic [13:0] REQ_ADDR,
	input wire logic [31:0] REQ_WDATA,
	output logic REQ_READY,
	output logic REQ_ACK,
	output logic RD_VALID,
	output logic [31:0] RD_DATA,
	input wire logic TS_ENABLE,
	output logic TS_READY,
	output logic FREQ_CHANGE_OK,
	output logic CK,
	output logic CK_N,
	output lpc_pkg::lpc_cmd_t CMD,
	output logic [15:0] DQ_O,
	output logic DQ_OE,
	input wire logic [15:0] DQ_I,
	output logic DQS_O,
	output logic DQS_OE,
	input wire logic DQS_I
);
	localparam logic [4:0] RD_WIN = 5'((CAS_LAT + 2) * lpc_pkg::CK_DIV + 4);
	localparam logic [17:0] TQ_END = 18'(T_TQ_CYC);
	// ----------------------------------------
	// State
	// ----------------------------------------
	lpc_pkg::lpc_state_t st_q, st_d;
	lpc_pkg::lpc_cmd_t cmd_q, cmd_d;
	lpc_pkg::lpc_op_t op;
	logic [lpc_pkg::TW-1:0] bank_q [lpc_pkg::NBANK];
	logic [lpc_pkg::NBANK-1:0] bank_free;
	logic [lpc_pkg::TW-1:0] rrd_q, gate_q, t_rc, t_rrd, t_rp, t_dal;
	logic [lpc_pkg::REFI_W-1:0] refi_q;
	logic [3:0] owed_q;
	logic [2:0] wph_q, wph_d;
	logic [4:0] rph_q;
	logic [31:0] wdata_q;
	logic [15:0] dq_s1, dq_s2, beat0_q;
	logic [17:0] ts_q;
	logic dqs_s1, dqs_s2, dqs_s3, got0_q;
	logic ck_q, ckn_q, apre_q, ready_q;
	logic all_free, legal, take, force_ref, auto_pre, auto_ref, auto_exit, refi_tick, ref_now;
	logic [1:0] ba_eff;
	logic [13:0] addr_eff;

	// ----------------------------------------
	// Grade selection and legality
	// ----------------------------------------
	assign t_rc = FAST_GRADE ? lpc_pkg::T_RC_FAST_CYC : lpc_pkg::T_RC_SLOW_CYC;
	assign t_rrd = FAST_GRADE ? lpc_pkg::T_RRD_FAST_CYC : lpc_pkg::T_RRD_SLOW_CYC;
	assign t_rp = FAST_GRADE ? lpc_pkg::T_RP_FAST_CYC : lpc_pkg::T_RP_SLOW_CYC;
	assign t_dal = FAST_GRADE ? lpc_pkg::T_DAL_FAST_CYC : lpc_pkg::T_DAL_SLOW_CYC;
	assign all_free = &bank_free;
	// Counters at zero mean the command may go on this edge
	assign legal = (gate_q == '0) && (
		(st_q == lpc_pkg::ST_RUN && (
			(REQ_CMD == lpc_pkg::OP_ACT && bank_free[REQ_BANK] && rrd_q == '0) ||
			((REQ_CMD == lpc_pkg::OP_READ || REQ_CMD == lpc_pkg::OP_WRITE)
				&& wph_q == '0 && rph_q == '0) ||
			REQ_CMD == lpc_pkg::OP_PRE || REQ_CMD == lpc_pkg::OP_NOP ||
			(REQ_CMD == lpc_pkg::OP_REF && all_free) ||
			((REQ_CMD == lpc_pkg::OP_SREF || REQ_CMD == lpc_pkg::OP_PDN) && all_free
				&& wph_q == '0 && rph_q == '0))) ||
		(st_q != lpc_pkg::ST_RUN && REQ_CMD == lpc_pkg::OP_EXIT));
	assign force_ref = owed_q >= lpc_pkg::REF_POST_MAX;
	assign take = ck_q && ready_q && REQ_VALID && legal;
	assign auto_pre = ck_q && force_ref && st_q == lpc_pkg::ST_RUN && !apre_q && all_free
		&& gate_q == '0 && wph_q == '0 && rph_q == '0;
	assign auto_ref = ck_q && force_ref && st_q == lpc_pkg::ST_RUN && apre_q && all_free
		&& gate_q == '0;
	assign auto_exit = ck_q && force_ref && st_q == lpc_pkg::ST_PDN && gate_q == '0;
	assign op = take ? REQ_CMD : auto_pre ? lpc_pkg::OP_PRE : auto_ref ? lpc_pkg::OP_REF :
		auto_exit ? lpc_pkg::OP_EXIT : lpc_pkg::OP_NOP;
	assign ba_eff = take ? REQ_BANK : 2'h0;
	assign addr_eff = take ? REQ_ADDR : 14'(1 << lpc_pkg::AP_BIT);
	// Counter runs 0 to count-1 so one tick falls every average interval
	assign refi_tick = (refi_q == lpc_pkg::T_REFI_CYC - 10'h1) && st_q != lpc_pkg::ST_SREF;
	assign ref_now = op == lpc_pkg::OP_REF;

	// ----------------------------------------
	// Command pins and power state
	// ----------------------------------------
	always_comb begin
		cmd_d = cmd_q;
		st_d = st_q;
		if (ck_q) begin
			cmd_d.cs_n = 1'b0;
			cmd_d.ba = ba_eff;
			cmd_d.addr = addr_eff;
			cmd_d.rcw_n = lpc_pkg::PIN_NOP;
			cmd_d.cke = (st_q == lpc_pkg::ST_RUN);
			case (op)
				lpc_pkg::OP_ACT: cmd_d.rcw_n = lpc_pkg::PIN_ACT;
				lpc_pkg::OP_READ: cmd_d.rcw_n = lpc_pkg::PIN_READ;
				lpc_pkg::OP_WRITE: cmd_d.rcw_n = lpc_pkg::PIN_WRITE;
				lpc_pkg::OP_PRE: cmd_d.rcw_n = lpc_pkg::PIN_PRE;
				lpc_pkg::OP_REF: cmd_d.rcw_n = lpc_pkg::PIN_REF;
				lpc_pkg::OP_SREF: begin
					cmd_d.rcw_n = lpc_pkg::PIN_REF;
					cmd_d.cke = 1'b0;
					st_d = lpc_pkg::ST_SREF;
				end
				lpc_pkg::OP_PDN: begin
					cmd_d.cke = 1'b0;
					st_d = lpc_pkg::ST_PDN;
				end
				lpc_pkg::OP_EXIT: begin
					cmd_d.cke = 1'b1;
					st_d = lpc_pkg::ST_RUN;
				end
				default: cmd_d.rcw_n = lpc_pkg::PIN_NOP;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			ck_q <= 1'b0;
			ckn_q <= 1'b1;
			st_q <= lpc_pkg::ST_PDN;
			cmd_q <= '{cke: 1'b0, cs_n: 1'b1, rcw_n: lpc_pkg::PIN_NOP, ba: 2'h0, addr: 14'h0};
			ready_q <= 1'b0;
			REQ_ACK <= 1'b0;
		end else begin
			ck_q <= !ck_q;
			ckn_q <= ck_q;
			st_q <= st_d;
			cmd_q <= cmd_d;
			ready_q <= !ck_q && !force_ref;
			REQ_ACK <= take;
		end
	end
	assign CK = ck_q;
	assign CK_N = ckn_q;
	assign CMD = cmd_q;
	assign REQ_READY = ready_q;

	// ----------------------------------------
	// Spacing counters
	// ----------------------------------------
	for (genvar b = 0; b < lpc_pkg::NBANK; b++) begin : g_bank
		logic hit, pre_hit;
		assign hit = ba_eff == 2'(b);
		assign pre_hit = op == lpc_pkg::OP_PRE && (hit || addr_eff[lpc_pkg::AP_BIT]);
		assign bank_free[b] = bank_q[b] == '0;
		always_ff @(posedge CLK) begin
			if (!RESET_N) begin
				bank_q[b] <= '0;
			end else if (op == lpc_pkg::OP_ACT && hit) begin
				bank_q[b] <= t_rc - 8'h1;
			end else if (op == lpc_pkg::OP_WRITE && hit && addr_eff[lpc_pkg::AP_BIT]) begin
				bank_q[b] <= t_dal + 8'(lpc_pkg::WPH_LAST);
			end else if (pre_hit || (op == lpc_pkg::OP_READ && hit && addr_eff[lpc_pkg::AP_BIT])) begin
				bank_q[b] <= t_rp + 8'(lpc_pkg::CK_DIV);
			end else if (bank_q[b] != '0) begin
				bank_q[b] <= bank_q[b] - 8'h1;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			rrd_q <= '0;
			gate_q <= '0;
			apre_q <= 1'b0;
			refi_q <= '0;
			owed_q <= '0;
		end else begin
			rrd_q <= (op == lpc_pkg::OP_ACT) ? t_rrd - 8'h1 :
				(rrd_q != '0) ? rrd_q - 8'h1 : rrd_q;
			if (ref_now)
				gate_q <= lpc_pkg::T_RFC_CYC - 8'h1;
			else if (op == lpc_pkg::OP_EXIT && st_q == lpc_pkg::ST_SREF)
				gate_q <= lpc_pkg::T_XSR_CYC;
			else if (op == lpc_pkg::OP_EXIT)
				gate_q <= lpc_pkg::T_XP_CYC;
			else if (gate_q != '0)
				gate_q <= gate_q - 8'h1;
			apre_q <= auto_pre ? 1'b1 : ref_now ? 1'b0 : apre_q;
			refi_q <= (refi_tick || st_q == lpc_pkg::ST_SREF) ? '0 : refi_q + 10'h1;
			// Self refresh restarts the refresh budget; otherwise credit and debit
			if (op == lpc_pkg::OP_SREF || st_q == lpc_pkg::ST_SREF)
				owed_q <= '0;
			else
				owed_q <= owed_q + {3'h0, refi_tick} - {3'h0, ref_now && owed_q != '0};
		end
	end

	// ----------------------------------------
	// Write strobe and data
	// ----------------------------------------
	// Only one write in flight, so every preamble starts from high impedance
	assign wph_d = (op == lpc_pkg::OP_WRITE) ? 3'h1 :
		(wph_q == lpc_pkg::WPH_LAST || wph_q == '0) ? 3'h0 : wph_q + 3'h1;
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			wph_q <= '0;
			wdata_q <= '0;
			DQS_OE <= 1'b0;
			DQS_O <= 1'b0;
			DQ_OE <= 1'b0;
			DQ_O <= '0;
		end else begin
			wph_q <= wph_d;
			if (op == lpc_pkg::OP_WRITE)
				wdata_q <= REQ_WDATA;
			DQS_OE <= wph_d != '0;
			DQS_O <= wph_d == lpc_pkg::WPH_DQS_HI;
			DQ_OE <= wph_d == lpc_pkg::WPH_DQ0 || wph_d == lpc_pkg::WPH_DQS_HI;
			// Edge-aligned at CLK grain; pad delay must centre DQ in the strobe eye
			DQ_O <= (wph_d == lpc_pkg::WPH_DQ0) ? wdata_q[15:0] : wdata_q[31:16];
		end
	end

	// ----------------------------------------
	// Read capture
	// ----------------------------------------
	// Strobe sampled at 100 MHz: one CLK per strobe phase is the least margin
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			dq_s1 <= '0;
			dq_s2 <= '0;
			dqs_s1 <= 1'b0;
			dqs_s2 <= 1'b0;
			dqs_s3 <= 1'b0;
			rph_q <= '0;
			got0_q <= 1'b0;
			beat0_q <= '0;
			RD_VALID <= 1'b0;
			RD_DATA <= '0;
		end else begin
			dq_s1 <= DQ_I;
			dq_s2 <= dq_s1;
			dqs_s1 <= DQS_I;
			dqs_s2 <= dqs_s1;
			dqs_s3 <= dqs_s2;
			RD_VALID <= 1'b0;
			if (op == lpc_pkg::OP_READ) begin
				rph_q <= RD_WIN;
				got0_q <= 1'b0;
			end else if (rph_q != '0) begin
				rph_q <= rph_q - 5'h1;
				if (dqs_s2 && !dqs_s3 && !got0_q) begin
					beat0_q <= dq_s2;
					got0_q <= 1'b1;
				end else if (!dqs_s2 && dqs_s3 && got0_q) begin
					RD_DATA <= {dq_s2, beat0_q};
					RD_VALID <= 1'b1;
					rph_q <= '0;
				end
			end
		end
	end

	// ----------------------------------------
	// Status
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			ts_q <= '0;
			TS_READY <= 1'b0;
			FREQ_CHANGE_OK <= 1'b0;
		end else begin
			ts_q <= !TS_ENABLE ? '0 : (ts_q == TQ_END) ? ts_q : ts_q + 18'h1;
			TS_READY <= TS_ENABLE && ts_q == TQ_END;
			FREQ_CHANGE_OK <= st_d != lpc_pkg::ST_RUN && gate_q == '0;
		end
	end
endmodule : lpc_ctrl
`default_nettype wire

/* File: logic/lpc_pkg.sv */
// Purpose: Constants, types and timing counts for the low-power DDR command controller
// Assumes: CLK at 100 MHz, device clock CK made by dividing CLK by two
// Notes: Counts are in CLK cycles; least times round up, longest times round down
`default_nettype none
package lpc_pkg;
	// ----------------------------------------
	// Clocking
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int CK_DIV = 2;
	localparam int TCK_NS = CLK_PERIOD_NS * CK_DIV;
	localparam int TW = 8;
	localparam int REFI_W = 10;
	localparam int NBANK = 4;
	// ----------------------------------------
	// Times as printed
	// ----------------------------------------
	localparam int T_RC_SLOW_NS = 60;
	localparam int T_RC_FAST_NS = 55;
	localparam int T_RRD_SLOW_NS = 12;
	localparam int T_RRD_FAST_NS = 10;
	localparam int T_RP_SLOW_NS = 18;
	localparam int T_RP_FAST_NS = 15;
	localparam int T_WR_NS = 15;
	localparam int T_RFC_NS = 110;
	localparam int T_XSR_NS = 200;
	localparam int T_XP_NS = 25;
	localparam int T_REFI_NS = 7800;
	localparam int T_TQ_MS = 2;
	localparam logic [3:0] REF_POST_MAX = 4'h8;
	// ----------------------------------------
	// Derived cycle counts
	// ----------------------------------------
	function automatic int up(input int ns, input int per);
		return (ns + per - 1) / per;
	endfunction : up
	localparam logic [TW-1:0] T_RC_SLOW_CYC = TW'(up(T_RC_SLOW_NS, CLK_PERIOD_NS));
	localparam logic [TW-1:0] T_RC_FAST_CYC = TW'(up(T_RC_FAST_NS, CLK_PERIOD_NS));
	localparam logic [TW-1:0] T_RRD_SLOW_CYC = TW'(up(T_RRD_SLOW_NS, CLK_PERIOD_NS));
	localparam logic [TW-1:0] T_RRD_FAST_CYC = TW'(up(T_RRD_FAST_NS, CLK_PERIOD_NS));
	localparam logic [TW-1:0] T_RP_SLOW_CYC = TW'(up(T_RP_SLOW_NS, CLK_PERIOD_NS));
	localparam logic [TW-1:0] T_RP_FAST_CYC = TW'(up(T_RP_FAST_NS, CLK_PERIOD_NS));
	// Write recovery plus precharge, each rounded up in whole CK periods
	localparam logic [TW-1:0] T_DAL_SLOW_CYC =
		TW'((up(T_WR_NS, TCK_NS) + up(T_RP_SLOW_NS, TCK_NS)) * CK_DIV);
	localparam logic [TW-1:0] T_DAL_FAST_CYC =
		TW'((up(T_WR_NS, TCK_NS) + up(T_RP_FAST_NS, TCK_NS)) * CK_DIV);
	localparam logic [TW-1:0] T_RFC_CYC = TW'(up(T_RFC_NS, CLK_PERIOD_NS));
	// Exit waits never shorter than the CK pulses the device must see
	localparam int XSR_RAW = up(T_XSR_NS, CLK_PERIOD_NS);
	localparam int XP_RAW = up(T_XP_NS, CLK_PERIOD_NS);
	localparam logic [TW-1:0] T_XSR_CYC = TW'((XSR_RAW > 3 * CK_DIV) ? XSR_RAW : 3 * CK_DIV);
	localparam logic [TW-1:0] T_XP_CYC = TW'((XP_RAW > 2 * CK_DIV) ? XP_RAW : 2 * CK_DIV);
	localparam logic [REFI_W-1:0] T_REFI_CYC = REFI_W'(T_REFI_NS / CLK_PERIOD_NS);
	localparam int T_TQ_CYC_DFLT = T_TQ_MS * 1000000 / CLK_PERIOD_NS;
	// Write strobe phases counted from the edge that issues WRITE
	localparam logic [2:0] WPH_DQ0 = 3'h3;
	localparam logic [2:0] WPH_DQS_HI = 3'h4;
	localparam logic [2:0] WPH_LAST = 3'h5;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [3:0] {
		OP_NOP = 4'h0, OP_ACT = 4'h1, OP_READ = 4'h2, OP_WRITE = 4'h3, OP_PRE = 4'h4,
		OP_REF = 4'h5, OP_SREF = 4'h6, OP_PDN = 4'h7, OP_EXIT = 4'h8
	} lpc_op_t;
	typedef enum logic [1:0] {ST_RUN = 2'h0, ST_PDN = 2'h1, ST_SREF = 2'h3} lpc_state_t;
	localparam logic [2:0] PIN_NOP = 3'h7;
	localparam logic [2:0] PIN_ACT = 3'h3;
	localparam logic [2:0] PIN_READ = 3'h5;
	localparam logic [2:0] PIN_WRITE = 3'h4;
	localparam logic [2:0] PIN_PRE = 3'h2;
	localparam logic [2:0] PIN_REF = 3'h1;
	localparam int AP_BIT = 10;
	typedef struct packed {
		logic cke;
		logic cs_n;
		logic [2:0] rcw_n;
		logic [1:0] ba;
		logic [13:0] addr;
	} lpc_cmd_t;
endpackage : lpc_pkg
`default_nettype wire
